//--- adc_port_pkg.sv
// constants, field layouts and states shared by both ends of the ADC link
// assumes both ends run on the same SYS_CLK of 10 MHz
package adc_port_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PART_MIN_NS = 40;
  localparam int PART_MAX_NS = 500;
  localparam int FULL_MIN_NS = 1200;
  localparam int PART_READY_NS = 120;
  localparam int FULL_READY_MS = 15;
  localparam int CONV_NS = 1000;
  localparam int PART_MIN_CYC =
    (PART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PART_MAX_CYC = PART_MAX_NS / CLK_PERIOD_NS;
  localparam int FULL_MIN_CYC =
    (FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PART_READY_CYC =
    (PART_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_READY_CYC = FULL_READY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_PART_LOW_CYC = PART_MIN_CYC + 2;
  localparam int HOST_FULL_LOW_CYC = FULL_MIN_CYC + 1;
  localparam int HOST_ACC_CYC = 2;
  // ----------------------------------------------------------------------
  // parallel command word
  // ----------------------------------------------------------------------
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_HI = 14;
  localparam int CMD_ADDR_LO = 9;
  localparam int CMD_DATA_HI = 8;
  localparam logic [5:0] CHAN_REG_ADDR = 6'h03;
  localparam logic [8:0] CHAN_REG_RESET = 9'h000;
  localparam int REG_COUNT = 8;
  // ----------------------------------------------------------------------
  // host registers on AHB-Lite
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_CMD = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_RDATA = 4'hC;
  localparam int CFG_CHSEL_LO = 0;
  localparam int CFG_RANGE_LO = 3;
  localparam int CFG_REF_BIT = 5;
  localparam int CFG_IF_BIT = 6;
  localparam int CFG_BURST_BIT = 7;
  localparam int CFG_SEQ_BIT = 8;
  localparam logic [8:0] CFG_RESET = 9'h068;
  localparam int CMD_OP_LO = 16;
  localparam logic [2:0] OP_PARTIAL = 3'h1;
  localparam logic [2:0] OP_FULL = 3'h2;
  localparam logic [2:0] OP_CONVERT = 3'h3;
  localparam logic [2:0] OP_WRITE = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;

  typedef enum logic [2:0] {
    H_IDLE, H_RST_LOW, H_GUARD, H_CONV_HI, H_CONV_WAIT, H_ACC, H_HOLD
  } host_state_t;
endpackage

//--- adc_link_if.sv
// link between the ADC device end and its host controller end
// assumes both ends are clocked by the same SYS_CLK
`timescale 1ns/10ps
interface adc_link_if;
  logic reset_n;
  logic conversion_start;
  logic busy;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [15:0] host_db_out;
  logic host_db_oe_n;
  logic [15:0] dev_db_out;
  logic dev_db_oe_n;
  logic [15:0] parallel_data_lines;
  logic [2:0] channel_pair_select_pins;
  logic [1:0] range_mode_select_pins;
  logic reference_choice_pin;
  logic interface_type_pin;
  logic burst_enable_pin;
  logic sequencer_enable_pin;

  // bus level resolved from the enables; an undriven bus floats high
  assign parallel_data_lines = !dev_db_oe_n ? dev_db_out :
                               !host_db_oe_n ? host_db_out : 16'hFFFF;

  modport device_end (
    input reset_n, conversion_start, cs_n, rd_n, wr_n, parallel_data_lines,
    input channel_pair_select_pins, range_mode_select_pins,
    input reference_choice_pin, interface_type_pin,
    input burst_enable_pin, sequencer_enable_pin,
    output busy, dev_db_out, dev_db_oe_n
  );
  modport host_end (
    output reset_n, conversion_start, cs_n, rd_n, wr_n,
    output host_db_out, host_db_oe_n,
    output channel_pair_select_pins, range_mode_select_pins,
    output reference_choice_pin, interface_type_pin,
    output burst_enable_pin, sequencer_enable_pin,
    input busy, parallel_data_lines
  );
endinterface // adc_link_if

//--- adc_device_end.sv
// device end: reset decoding, latched configuration, conversion handshake
// and the 16-bit parallel port with its small register file
// assumes the link signals come from logic on the same SYS_CLK
`timescale 1ns/10ps
module adc_device_end
  import adc_port_pkg::*;
#(
  parameter int FULL_READY_CYCLES = FULL_READY_CYC,
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int REG_NUM = REG_COUNT
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // link
  adc_link_if.device_end LINK,
  // analog stand-ins sampled at the end of a conversion
  input wire logic [15:0] SAMPLE_A,
  input wire logic [15:0] SAMPLE_B,
  // configuration and ready flag seen by the converter core
  output logic SW_MODE,
  output logic [1:0] INPUT_RANGE,
  output logic INT_REF,
  output logic PARALLEL_IF,
  output logic BURST_EN,
  output logic SEQ_EN,
  output logic [2:0] CHANNEL_PAIR,
  output logic READY
);
  localparam int RW = $clog2(FULL_READY_CYCLES + 1);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int AW = $clog2(REG_NUM);

  initial begin
    if (REG_NUM < 2 || REG_NUM > 64 || (1 << AW) != REG_NUM ||
        int'(CHAN_REG_ADDR) >= REG_NUM || CONV_CYCLES < 1 ||
        FULL_READY_CYCLES < 1)
      $error("adc_device_end: unsupported parameter values");
  end

  typedef struct packed {
    logic [3:0] low_cnt;
    logic rst_prev;
    logic [RW-1:0] ready_cnt;
    logic sw_mode;
    logic [1:0] range_l;
    logic int_ref;
    logic par_if;
    logic burst_en;
    logic seq_en;
    logic [2:0] chan;
    logic busy;
    logic [CW-1:0] conv_cnt;
    logic conv_prev;
    logic rd_prev;
    logic wr_prev;
    logic [15:0] res_a;
    logic [15:0] res_b;
    logic [1:0] rd_idx;
    logic reg_pending;
    logic [15:0] dout;
    logic [REG_NUM-1:0][8:0] regs;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{
    low_cnt: 4'h0, rst_prev: 1'b1, ready_cnt: '0, sw_mode: 1'b1,
    range_l: 2'h0, int_ref: 1'b1, par_if: 1'b1, burst_en: 1'b0,
    seq_en: 1'b0, chan: 3'h0, busy: 1'b0, conv_cnt: '0,
    conv_prev: 1'b0, rd_prev: 1'b1, wr_prev: 1'b1, res_a: 16'h0000,
    res_b: 16'h0000, rd_idx: 2'h0, reg_pending: 1'b0, dout: 16'h0000,
    regs: '0
  };

  dev_state_t s;
  dev_state_t n;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [5:0] a;
    logic [15:0] db;
    a = LINK.parallel_data_lines[CMD_ADDR_HI:CMD_ADDR_LO];
    db = LINK.parallel_data_lines;
    n = s;
    n.rst_prev = LINK.reset_n;
    n.conv_prev = LINK.conversion_start;
    n.rd_prev = LINK.rd_n;
    n.wr_prev = LINK.wr_n;
    if (!LINK.reset_n) begin
      // count the low time; everything in flight stops at once
      if (s.low_cnt != 4'hF)
        n.low_cnt = s.low_cnt + 4'h1;
      n.busy = 1'b0;
      n.conv_cnt = '0;
    end else if (!s.rst_prev) begin
      if (int'(s.low_cnt) > PART_MAX_CYC) begin
        // full reset; an undefined middle length is also taken as full
        n = DEV_RESET;
        n.rst_prev = 1'b1;
        n.conv_prev = LINK.conversion_start;
        n.rd_prev = LINK.rd_n;
        n.wr_prev = LINK.wr_n;
        n.ready_cnt = RW'(FULL_READY_CYCLES);
        n.sw_mode = (LINK.range_mode_select_pins == 2'h0);
        n.range_l = LINK.range_mode_select_pins;
        n.int_ref = LINK.reference_choice_pin;
        n.par_if = LINK.interface_type_pin;
        n.burst_en = !n.sw_mode && LINK.burst_enable_pin;
        n.seq_en = !n.sw_mode && LINK.sequencer_enable_pin;
      end else begin
        // partial: configuration and register values survive, except the channel register, reset to CHAN_REG_RESET, and the hardware-mode pair, retaken below
        n.ready_cnt = RW'(PART_READY_CYC);
        n.res_a = 16'h0000;
        n.res_b = 16'h0000;
        n.rd_idx = 2'h0;
        n.reg_pending = 1'b0;
        n.regs[CHAN_REG_ADDR[AW-1:0]] = CHAN_REG_RESET;
      end
      n.low_cnt = 4'h0;
      if (!n.sw_mode)
        n.chan = LINK.channel_pair_select_pins;
    end else begin
      if (s.ready_cnt != '0)
        n.ready_cnt = s.ready_cnt - RW'(1);
      // ------------------------------------------------------------------
      // conversion handshake
      // ------------------------------------------------------------------
      if (s.busy) begin
        n.conv_cnt = s.conv_cnt - CW'(1);
        if (s.conv_cnt == CW'(1)) begin
          n.busy = 1'b0;
          n.res_a = SAMPLE_A;
          n.res_b = SAMPLE_B;
          n.rd_idx = 2'h0;
          n.reg_pending = 1'b0;
          // pins are taken at the busy fall; the host does not hold them against config writes
          if (!s.sw_mode)
            n.chan = LINK.channel_pair_select_pins;
        end
      end else if (s.ready_cnt == '0 && LINK.conversion_start &&
                   !s.conv_prev) begin
        n.busy = 1'b1;
        n.conv_cnt = CW'(CONV_CYCLES);
      end
      // ------------------------------------------------------------------
      // parallel port strobes
      // ------------------------------------------------------------------
      if (!LINK.cs_n && !LINK.rd_n && s.rd_prev) begin
        if (s.reg_pending) begin
          n.reg_pending = 1'b0;
        end else begin
          unique case (s.rd_idx)
            2'h0: n.dout = s.res_a;
            2'h1: n.dout = s.res_b;
            default: n.dout = 16'h0000;
          endcase
          if (s.rd_idx != 2'h3)
            n.rd_idx = s.rd_idx + 2'h1;
        end
      end
      // the write edge is taken only in software mode
      if (!LINK.cs_n && LINK.wr_n && !s.wr_prev && s.sw_mode) begin
        if (db[CMD_WRITE_BIT]) begin
          if (int'(a) < REG_NUM)
            n.regs[a[AW-1:0]] = db[CMD_DATA_HI:0];
        end else begin
          n.dout = (int'(a) < REG_NUM) ?
                   {7'h00, s.regs[a[AW-1:0]]} : 16'h0000;
          n.reg_pending = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)
      s <= DEV_RESET;
    else
      s <= n;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign LINK.busy = s.busy;
  assign LINK.dev_db_out = s.dout;
  // drive only while both strobes are low; select high floats the bus
  assign LINK.dev_db_oe_n = !(!LINK.cs_n && !LINK.rd_n &&
                              LINK.reset_n);
  assign SW_MODE = s.sw_mode;
  // range follows the live pins in hardware mode
  assign INPUT_RANGE = s.sw_mode ? 2'h0 :
                       LINK.range_mode_select_pins;
  assign INT_REF = s.int_ref;
  assign PARALLEL_IF = s.par_if;
  assign BURST_EN = s.burst_en;
  assign SEQ_EN = s.seq_en;
  assign CHANNEL_PAIR = s.sw_mode ? s.regs[CHAN_REG_ADDR[AW-1:0]][2:0] :
                        s.chan;
  assign READY = (s.ready_cnt == '0) && s.rst_prev && LINK.reset_n;
endmodule // adc_device_end

//--- adc_host_end.sv
// host end: AHB-Lite register slave that sequences resets, conversions
// and parallel bus accesses towards the ADC
// assumes one AHB-Lite master and the ADC on the same SYS_CLK
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module adc_host_end
  import adc_port_pkg::*;
#(
  parameter int FULL_READY_CYCLES = FULL_READY_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // link
  adc_link_if.host_end LINK
);
  localparam int RW = $clog2(FULL_READY_CYCLES + 1);

  initial begin
    if (FULL_READY_CYCLES < 1)
      $error("adc_host_end: unsupported parameter values");
  end

  typedef struct packed {
    logic a_valid;
    logic a_write;
    logic [3:0] a_addr;
    logic [8:0] cfg;
    host_state_t st;
    logic [RW-1:0] cnt;
    logic is_full;
    logic is_read;
    logic [15:0] rdata;
    logic rst_n;
    logic conv;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [15:0] db_out;
    logic db_oe_n;
  } host_reg_t;

  localparam host_reg_t HOST_RESET = '{
    a_valid: 1'b0, a_write: 1'b0, a_addr: 4'h0, cfg: CFG_RESET,
    st: H_IDLE, cnt: '0, is_full: 1'b0, is_read: 1'b0, rdata: 16'h0000,
    rst_n: 1'b1, conv: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
    db_out: 16'h0000, db_oe_n: 1'b1
  };

  host_reg_t s;
  host_reg_t n;

  always_comb begin
    logic cmd_go;
    logic sw_cfg;
    cmd_go = s.a_valid && s.a_write && s.a_addr == OFS_CMD &&
             s.st == H_IDLE;
    sw_cfg = s.cfg[CFG_RANGE_LO +: 2] == 2'h0;
    n = s;
    // --------------------------------------------------------------------
    // AHB-Lite: zero-wait slave, address phase registered
    // --------------------------------------------------------------------
    n.a_valid = HSEL && HREADY && HTRANS[1];
    n.a_write = HWRITE;
    n.a_addr = {HADDR[3:2], 2'h0};
    if (s.a_valid && s.a_write && s.a_addr == OFS_CFG)
      n.cfg = HWDATA[8:0];
    // --------------------------------------------------------------------
    // link sequencer
    // --------------------------------------------------------------------
    unique case (s.st)
      H_IDLE: begin
        if (cmd_go) begin
          unique case (HWDATA[CMD_OP_LO +: 3])
            OP_PARTIAL, OP_FULL: begin
              n.is_full = HWDATA[CMD_OP_LO +: 3] == OP_FULL;
              // fixed lengths keep clear of the undefined band
              n.cnt = n.is_full ? RW'(HOST_FULL_LOW_CYC - 1) :
                      RW'(HOST_PART_LOW_CYC - 1);
              n.rst_n = 1'b0;
              n.st = H_RST_LOW;
            end
            OP_CONVERT: begin
              n.conv = 1'b1;
              n.st = H_CONV_HI;
            end
            OP_WRITE, OP_READ: begin
              n.is_read = HWDATA[CMD_OP_LO +: 3] == OP_READ;
              n.cs_n = 1'b0;
              n.rd_n = !n.is_read;
              n.wr_n = n.is_read;
              n.db_out = HWDATA[15:0];
              n.db_oe_n = n.is_read;
              n.cnt = RW'(HOST_ACC_CYC - 1);
              n.st = H_ACC;
            end
            default: n.st = H_IDLE;
          endcase
        end
      end
      H_RST_LOW: begin
        if (s.cnt == '0) begin
          n.rst_n = 1'b1;
          n.cnt = s.is_full ? RW'(FULL_READY_CYCLES) :
                  RW'(PART_READY_CYC);
          n.st = H_GUARD;
        end else begin
          n.cnt = s.cnt - RW'(1);
        end
      end
      H_GUARD: begin
        if (s.cnt == '0) begin
          // throwaway conversion so later results are trustworthy
          n.conv = !s.is_full && sw_cfg;
          n.st = n.conv ? H_CONV_HI : H_IDLE;
        end else begin
          n.cnt = s.cnt - RW'(1);
        end
      end
      H_CONV_HI: begin
        if (LINK.busy) begin
          n.conv = 1'b0;
          n.st = H_CONV_WAIT;
        end
      end
      H_CONV_WAIT: begin
        // waits for busy to fall; a config write here still moves the channel pins
        if (!LINK.busy)
          n.st = H_IDLE;
      end
      H_ACC: begin
        if (s.cnt == '0) begin
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          if (s.is_read)
            n.rdata = LINK.parallel_data_lines;
          n.st = H_HOLD;
        end else begin
          n.cnt = s.cnt - RW'(1);
        end
      end
      H_HOLD: begin
        n.cs_n = 1'b1;
        n.db_oe_n = 1'b1;
        n.st = H_IDLE;
      end
      default: n = HOST_RESET;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN)
      s <= HOST_RESET;
    else
      s <= n;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_comb begin
    HRDATA = 32'h00000000;
    if (s.a_valid && !s.a_write) begin
      unique case (s.a_addr)
        OFS_CFG: HRDATA = {23'h000000, s.cfg};
        OFS_STATUS: HRDATA = {29'h00000000, s.st == H_GUARD, LINK.busy,
                              s.st != H_IDLE};
        OFS_RDATA: HRDATA = {16'h0000, s.rdata};
        default: HRDATA = 32'h00000000;
      endcase
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign LINK.reset_n = s.rst_n;
  assign LINK.conversion_start = s.conv;
  assign LINK.cs_n = s.cs_n;
  assign LINK.rd_n = s.rd_n;
  assign LINK.wr_n = s.wr_n;
  assign LINK.host_db_out = s.db_out;
  assign LINK.host_db_oe_n = s.db_oe_n;
  assign LINK.channel_pair_select_pins = s.cfg[CFG_CHSEL_LO +: 3];
  assign LINK.range_mode_select_pins = s.cfg[CFG_RANGE_LO +: 2];
  assign LINK.reference_choice_pin = s.cfg[CFG_REF_BIT];
  assign LINK.interface_type_pin = s.cfg[CFG_IF_BIT];
  assign LINK.burst_enable_pin = s.cfg[CFG_BURST_BIT];
  assign LINK.sequencer_enable_pin = s.cfg[CFG_SEQ_BIT];
endmodule // adc_host_end

//--- adc_link_sva.sv
// checker for the link between the ADC device end and its host end
// assumes the link signals are same-clock logic on SYS_CLK
`timescale 1ns/10ps
module adc_link_sva
  import adc_port_pkg::*;
#(
  parameter int FULL_READY_CYCLES = FULL_READY_CYC
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // link
  input wire logic reset_n,
  input wire logic conversion_start,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] host_db_out,
  input wire logic host_db_oe_n,
  input wire logic dev_db_oe_n,
  input wire logic [2:0] channel_pair_select_pins
);
  // ----------------------------------------------------------------------
  // helper state: length of the last link reset and the guard after it
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] low_cnt;
    logic prev_rn;
    logic [31:0] guard;
  } mon_t;
  mon_t mon;
  mon_t next_mon;

  always_comb begin
    next_mon = mon;
    next_mon.prev_rn = reset_n;
    if (reset_n) begin
      next_mon.low_cnt = 5'h00;
    end else if (mon.low_cnt != 5'h1F) begin
      next_mon.low_cnt = mon.low_cnt + 5'h01;
    end
    // guard ends one sample early: the load edge itself is the first cycle
    if (reset_n && !mon.prev_rn && mon.low_cnt > 5'(PART_MAX_CYC)) begin
      next_mon.guard = 32'(FULL_READY_CYCLES - 1);
    end else if (mon.guard != 32'h0) begin
      next_mon.guard = mon.guard - 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      mon <= '0;
    end else begin
      mon <= next_mon;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  chk_reset_pulse_len: assert property (
    $rose(reset_n) |-> (mon.low_cnt >= 5'(PART_MIN_CYC) &&
      mon.low_cnt <= 5'(PART_MAX_CYC)) || mon.low_cnt >= 5'(FULL_MIN_CYC))
    else $error("link reset low for an undefined length");
  chk_partial_guard: assert property (
    $rose(reset_n) |-> !conversion_start [*2])
    else $error("conversion start too soon after reset release");
  chk_full_guard: assert property (
    $rose(conversion_start) |-> mon.guard == 32'h0)
    else $error("conversion start inside full reset guard");
  chk_busy_cause: assert property (
    $rose(busy) |-> conversion_start && $past(conversion_start) && reset_n)
    else $error("busy rose without a conversion start");
  chk_busy_length: assert property (
    $rose(busy) |-> busy [*8] ##1 busy ##1 busy ##1 !busy)
    else $error("busy did not last the conversion time");
  chk_pins_held: assert property (
    busy |-> $stable(channel_pair_select_pins))
    else $error("channel pins moved while busy");
  chk_read_drive: assert property (
    (!cs_n && !rd_n && reset_n) |-> !dev_db_oe_n)
    else $error("device not driving during a read");
  chk_bus_release: assert property (
    (cs_n || rd_n) |-> dev_db_oe_n)
    else $error("device drives the bus outside a read");
  chk_no_contention: assert property (
    !dev_db_oe_n |-> host_db_oe_n)
    else $error("both ends drive the data lines");
  chk_write_frame: assert property (
    $fell(wr_n) |-> (!cs_n && !host_db_oe_n) ##1
      (!host_db_oe_n && $stable(host_db_out)))
    else $error("write strobe without selected stable data");
endmodule // adc_link_sva

//--- adc_parallel_port_reset_config_tb.sv
// testbench: host end driven over AHB-Lite, facing the device end
// assumes the package constants and a 10 MHz SYS_CLK
`timescale 1ns/10ps
module adc_parallel_port_reset_config_tb;
  import adc_port_pkg::*;
  localparam int READY_CYC = 20;
  localparam int TIMEOUT_CYC = 20000;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic sw_mode, int_ref, parallel_if, burst_en, seq_en, ready;
  logic [1:0] input_range;
  logic [2:0] channel_pair;
  logic [31:0] rd;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 sys_clk = ~sys_clk;

  adc_link_if u_adc_link_if ();
  adc_device_end #(.FULL_READY_CYCLES(READY_CYC)) u_adc_device_end (
    .SYS_CLK(sys_clk), .RSTN(rstn), .LINK(u_adc_link_if),
    .SAMPLE_A(sample_a), .SAMPLE_B(sample_b), .SW_MODE(sw_mode),
    .INPUT_RANGE(input_range), .INT_REF(int_ref),
    .PARALLEL_IF(parallel_if), .BURST_EN(burst_en), .SEQ_EN(seq_en),
    .CHANNEL_PAIR(channel_pair), .READY(ready));
  adc_host_end #(.FULL_READY_CYCLES(READY_CYC)) u_adc_host_end (
    .SYS_CLK(sys_clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata),
    .HRESP(hresp), .LINK(u_adc_link_if));
  adc_link_sva #(.FULL_READY_CYCLES(READY_CYC)) u_adc_link_sva (
    .SYS_CLK(sys_clk), .RSTN(rstn), .reset_n(u_adc_link_if.reset_n),
    .conversion_start(u_adc_link_if.conversion_start),
    .busy(u_adc_link_if.busy), .cs_n(u_adc_link_if.cs_n),
    .rd_n(u_adc_link_if.rd_n), .wr_n(u_adc_link_if.wr_n),
    .host_db_out(u_adc_link_if.host_db_out),
    .host_db_oe_n(u_adc_link_if.host_db_oe_n),
    .dev_db_oe_n(u_adc_link_if.dev_db_oe_n),
    .channel_pair_select_pins(u_adc_link_if.channel_pair_select_pins));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single AHB-Lite transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // flags: sequencer, burst, interface type, reference
  function automatic logic [8:0] cfg(input logic [3:0] fl,
                                     input logic [1:0] rg,
                                     input logic [2:0] ch);
    return {fl, rg, ch};
  endfunction

  // status is polled until both the engine and the guard have finished
  task automatic cmd(input logic [2:0] op, input logic [15:0] word);
    int i;
    ahb(1'b1, {4'h0, OFS_CMD}, {13'h0000, op, word});
    i = 0;
    rd = 32'h1;
    while ((rd[0] | rd[2]) !== 1'b0 && i < 500) begin
      ahb(1'b0, {4'h0, OFS_STATUS}, 32'h0);
      i++;
    end
    check("engine idle", 32'(rd[0] | rd[2]), 32'h0);
  endtask

  task automatic bus_read(input string what, input logic [15:0] exp);
    cmd(OP_READ, 16'h0000);
    ahb(1'b0, {4'h0, OFS_RDATA}, 32'h0);
    check(what, {16'h0000, rd[15:0]}, {16'h0000, exp});
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    ahb(1'b0, {4'h0, OFS_CFG}, 32'h0);
    check("cfg reset", rd, {23'h0, CFG_RESET});
    check("hresp", 32'(hresp), 32'h0);
    // only address bits 3:2 are decoded, so 0x10 aliases the config word
    ahb(1'b0, 8'h10, 32'h0);
    check("cfg alias", rd, {23'h0, CFG_RESET});
    $display("test registers done");
    ahb(1'b1, {4'h0, OFS_CFG}, {23'h0, cfg(4'hF, 2'h1, 3'h5)});
    cmd(OP_FULL, 16'h0000);
    check("sw mode", 32'(sw_mode), 32'h0);
    check("range", 32'(input_range), 32'h1);
    check("ref", 32'(int_ref), 32'h1);
    check("if type", 32'(parallel_if), 32'h1);
    check("seq", 32'(seq_en), 32'h1);
    check("burst", 32'(burst_en), 32'h1);
    check("pair", 32'(channel_pair), 32'h5);
    check("ready", 32'(ready), 32'h1);
    ahb(1'b1, {4'h0, OFS_CFG}, {23'h0, cfg(4'h0, 2'h2, 3'h5)});
    // the config word lands at the edge the task returns on
    @(negedge sys_clk);
    check("range live", 32'(input_range), 32'h2);
    check("seq kept", 32'(seq_en), 32'h1);
    check("burst kept", 32'(burst_en), 32'h1);
    check("ref kept", 32'(int_ref), 32'h1);
    cmd(OP_WRITE, {1'b1, CHAN_REG_ADDR, 9'h002});
    check("hw pair", 32'(channel_pair), 32'h5);
    sample_a <= 16'h1234;
    sample_b <= 16'hABCD;
    ahb(1'b1, {4'h0, OFS_CFG}, {23'h0, cfg(4'h4, 2'h2, 3'h3)});
    cmd(OP_CONVERT, 16'h0000);
    check("next pair", 32'(channel_pair), 32'h3);
    bus_read("bank a", 16'h1234);
    bus_read("bank b", 16'hABCD);
    bus_read("extra", 16'h0000);
    cmd(OP_WRITE, {1'b0, CHAN_REG_ADDR, 9'h000});
    bus_read("hw reg read", 16'h0000);
    ahb(1'b1, {4'h0, OFS_CFG}, {23'h0, cfg(4'h4, 2'h2, 3'h6)});
    cmd(OP_PARTIAL, 16'h0000);
    check("pair at release", 32'(channel_pair), 32'h6);
    check("mode kept", 32'(sw_mode), 32'h0);
    check("seq after partial", 32'(seq_en), 32'h1);
    $display("test hardware mode done");
    ahb(1'b1, {4'h0, OFS_CFG}, {23'h0, cfg(4'hC, 2'h0, 3'h7)});
    cmd(OP_FULL, 16'h0000);
    check("sw mode", 32'(sw_mode), 32'h1);
    check("range sw", 32'(input_range), 32'h0);
    check("ref", 32'(int_ref), 32'h0);
    check("if type", 32'(parallel_if), 32'h0);
    check("seq sw", 32'(seq_en), 32'h0);
    check("burst sw", 32'(burst_en), 32'h0);
    check("pair default", 32'(channel_pair), 32'h0);
    cmd(OP_WRITE, {1'b1, CHAN_REG_ADDR, 9'h006});
    check("pair written", 32'(channel_pair), 32'h6);
    cmd(OP_WRITE, {1'b0, CHAN_REG_ADDR, 9'h1FF});
    bus_read("reg read", 16'h0006);
    cmd(OP_WRITE, {1'b1, 6'h0A, 9'h155});
    cmd(OP_WRITE, {1'b0, 6'h0A, 9'h000});
    bus_read("no reg", 16'h0000);
    sample_a <= 16'h0F0F;
    sample_b <= 16'hF00F;
    cmd(OP_CONVERT, 16'h0000);
    bus_read("sw bank a", 16'h0F0F);
    bus_read("sw bank b", 16'hF00F);
    $display("test software mode done");
    cmd(OP_PARTIAL, 16'h0000);
    check("mode kept", 32'(sw_mode), 32'h1);
    check("if kept", 32'(parallel_if), 32'h0);
    check("pair reset", 32'(channel_pair), 32'h0);
    check("ready", 32'(ready), 32'h1);
    sample_a <= 16'h5A5A;
    sample_b <= 16'hA5A5;
    cmd(OP_CONVERT, 16'h0000);
    bus_read("after partial a", 16'h5A5A);
    bus_read("after partial b", 16'hA5A5);
    $display("test partial reset done");
    end_of_test();
  end
endmodule // adc_parallel_port_reset_config_tb
